// file: hbg_gate_ctrl.v
/*
 full-bridge gate control: pin/register decoding, lockout, dead time,
 enable shutdown and diagnostic pin function select, axi4-lite slave.
 assumes pins are asynchronous to i_clock and are synchronised here;
 fault and temperature levels come from analog blocks elsewhere.
*/
`include "hbg_consts.vh"
`default_nettype none

module hbg_gate_ctrl #(
    parameter [31:0] PULSE_CYCLES  = `HBG_PULSE_CYCLES,
    parameter [31:0] ENABLE_TO_CYC = `HBG_ENABLE_TO_CYCLES
) (
    input  wire        i_clock,
    input  wire        i_sys_rst,
    input  wire        i_phase_a_high_pin,
    input  wire        i_phase_a_low_pin_n,
    input  wire        i_phase_b_high_pin_n,
    input  wire        i_phase_b_low_pin,
    input  wire        i_reset_sleep_n,
    input  wire        i_enable,
    input  wire        i_fault,
    input  wire        i_temp_indication,
    input  wire        i_offset_indication,
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         o_phase_a_high_gate,
    output reg         o_phase_a_low_gate,
    output reg         o_phase_b_high_gate,
    output reg         o_phase_b_low_gate,
    output reg         o_diagnostic_pin,
    output reg         o_open_load_current_select,
    output reg         o_sleep,
    output wire        o_irq
);

    // two-flop synchronisers for all pins
    reg  [7:0] sync1_q;
    reg  [7:0] sync2_q;
    wire [7:0] pins_raw = {i_offset_indication, i_temp_indication, i_fault, i_enable, i_reset_sleep_n,
                           i_phase_b_low_pin, i_phase_b_high_pin_n, i_phase_a_low_pin_n};
    reg        a_high_s1_q;
    reg        a_high_q;
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            sync1_q     <= 8'h00;
            sync2_q     <= 8'h00;
            a_high_s1_q <= 1'b0;
            a_high_q    <= 1'b0;
        end else begin
            sync1_q     <= pins_raw;
            sync2_q     <= sync1_q;
            a_high_s1_q <= i_phase_a_high_pin;
            a_high_q    <= a_high_s1_q;
        end
    end
    wire a_low_n_s  = sync2_q[0];
    wire b_high_n_s = sync2_q[1];
    wire b_low_s    = sync2_q[2];
    wire rst_n_s    = sync2_q[3];
    wire enable_s   = sync2_q[4];
    wire fault_s    = sync2_q[5];
    wire temp_s     = sync2_q[6];
    wire offset_s   = sync2_q[7];

    // registers
    reg  [3:0]  bridge_q;
    reg  [7:0]  config_q;
    reg  [15:0] dead_q;
    reg  [2:0]  irq_stat_q;
    reg  [2:0]  irq_mask_q;
    reg         fault_latch_q;
    reg         lock_event;
    wire [1:0]  dg_sel       = config_q[`HBG_CF_DG_LO +: 2];
    wire        monitor_mode = config_q[3];

    // axi4-lite write: address and data taken in either order
    reg         aw_have_q;
    reg         w_have_q;
    reg  [7:0]  aw_addr_q;
    reg  [31:0] w_data_q;
    reg  [3:0]  w_strb_q;
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
    wire        do_write = aw_have_q && w_have_q && !s_axi_bvalid;
    wire        wr_stat  = do_write && aw_addr_q == `HBG_OFF_IRQ_STAT && w_strb_q[0];

    // interrupt events
    reg         fault_prev_q;
    reg         en_prev_q;
    wire [2:0]  irq_event = {lock_event, en_prev_q & ~enable_s, fault_s & ~fault_prev_q};
    assign o_irq = |(irq_stat_q & irq_mask_q);

    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
            bridge_q      <= 4'h0;
            config_q      <= `HBG_CFG_RESET;
            dead_q        <= `HBG_DEAD_RESET;
            irq_stat_q    <= 3'b000;
            irq_mask_q    <= 3'b000;
            fault_prev_q  <= 1'b0;
            en_prev_q     <= 1'b0;
            fault_latch_q <= 1'b0;
        end else begin
            fault_prev_q <= fault_s;
            en_prev_q    <= enable_s;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (do_write) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= 2'b00;
                case (aw_addr_q)
                    `HBG_OFF_BRIDGE:   if (w_strb_q[0]) bridge_q <= w_data_q[3:0];
                    `HBG_OFF_CONFIG:   if (w_strb_q[0]) config_q <= w_data_q[7:0];
                    `HBG_OFF_DEAD: begin
                        if (w_strb_q[0]) dead_q[7:0]  <= w_data_q[7:0];
                        if (w_strb_q[1]) dead_q[15:8] <= w_data_q[15:8];
                    end
                    `HBG_OFF_IRQ_STAT: ;
                    `HBG_OFF_IRQ_MASK: if (w_strb_q[0]) irq_mask_q <= w_data_q[2:0];
                    `HBG_OFF_STATUS:   ;
                    default:           s_axi_bresp <= 2'b10;
                endcase
            end
            // set wins over write-one-to-clear
            irq_stat_q <= (irq_stat_q & ~(wr_stat ? w_data_q[2:0] : 3'b000)) | irq_event;
            // faults latch until a reset_sleep_n low pulse
            if (!rst_n_s)
                fault_latch_q <= 1'b0;
            else if (fault_s)
                fault_latch_q <= 1'b1;
        end
    end

    // axi4-lite read
    assign s_axi_arready = !s_axi_rvalid;
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            case (s_axi_araddr[7:0])
                `HBG_OFF_BRIDGE:   s_axi_rdata <= {28'h000_0000, bridge_q};
                `HBG_OFF_CONFIG:   s_axi_rdata <= {24'h00_0000, config_q};
                `HBG_OFF_DEAD:     s_axi_rdata <= {16'h0000, dead_q};
                `HBG_OFF_STATUS:   s_axi_rdata <= {24'h00_0000, fault_latch_q, ~rst_n_s, enable_s, fault_s,
                                                   o_phase_b_low_gate, o_phase_b_high_gate,
                                                   o_phase_a_low_gate, o_phase_a_high_gate};
                `HBG_OFF_IRQ_STAT: s_axi_rdata <= {29'h0000_0000, irq_stat_q};
                `HBG_OFF_IRQ_MASK: s_axi_rdata <= {29'h0000_0000, irq_mask_q};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // demand decoding: pins or'd with register bits
    wire a_hi_dem = a_high_q | bridge_q[`HBG_BR_AH];
    wire a_lo_dem = ~a_low_n_s | bridge_q[`HBG_BR_AL];
    wire b_hi_dem = ~b_high_n_s | bridge_q[`HBG_BR_BH];
    wire b_lo_dem = b_low_s | bridge_q[`HBG_BR_BL];
    // 2'b10 high, 2'b01 low, else off
    wire [1:0] a_want = (a_hi_dem ^ a_lo_dem) ? {a_hi_dem, a_lo_dem} : 2'b00;
    wire [1:0] b_want = (b_hi_dem ^ b_lo_dem) ? {b_hi_dem, b_lo_dem} : 2'b00;

    // enable: en_off_q sets at once in direct mode, after a timeout in monitor mode; gates drop at once on enable_s low in both
    reg [31:0] en_cnt_q;
    reg        en_off_q;
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            en_cnt_q <= 32'h0000_0000;
            en_off_q <= 1'b1;
        end else if (enable_s) begin
            en_cnt_q <= 32'h0000_0000;
            en_off_q <= 1'b0;
        end else if (!monitor_mode || en_cnt_q >= ENABLE_TO_CYC - 32'h0000_0001) begin
            en_off_q <= 1'b1;
        end else begin
            en_cnt_q <= en_cnt_q + 32'h0000_0001;
        end
    end
    // decode only while awake and enabled
    wire run = rst_n_s && !en_off_q && !(monitor_mode ? 1'b0 : !enable_s);

    // dead time per phase: hold off until demand stable for dead_q cycles
    reg [1:0]  a_tgt_q, b_tgt_q, a_out_q, b_out_q;
    reg [15:0] a_cnt_q, b_cnt_q;
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            a_tgt_q <= 2'b00;
            b_tgt_q <= 2'b00;
            a_out_q <= 2'b00;
            b_out_q <= 2'b00;
            a_cnt_q <= 16'h0000;
            b_cnt_q <= 16'h0000;
        end else begin
            a_tgt_q <= a_want;
            b_tgt_q <= b_want;
            if (a_want != a_tgt_q || a_want == 2'b00) begin
                a_out_q <= 2'b00;
                a_cnt_q <= 16'h0000;
            end else if (a_cnt_q >= dead_q) begin
                a_out_q <= a_tgt_q;
            end else begin
                a_cnt_q <= a_cnt_q + 16'h0001;
            end
            if (b_want != b_tgt_q || b_want == 2'b00) begin
                b_out_q <= 2'b00;
                b_cnt_q <= 16'h0000;
            end else if (b_cnt_q >= dead_q) begin
                b_out_q <= b_tgt_q;
            end else begin
                b_cnt_q <= b_cnt_q + 16'h0001;
            end
        end
    end

    // final gates with hard lockout
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_phase_a_high_gate <= 1'b0;
            o_phase_a_low_gate  <= 1'b0;
            o_phase_b_high_gate <= 1'b0;
            o_phase_b_low_gate  <= 1'b0;
            lock_event          <= 1'b0;
        end else begin
            o_phase_a_high_gate <= run && a_out_q[1] && !a_out_q[0] && enable_s;
            o_phase_a_low_gate  <= run && a_out_q[0] && !a_out_q[1] && enable_s;
            o_phase_b_high_gate <= run && b_out_q[1] && !b_out_q[0] && enable_s;
            o_phase_b_low_gate  <= run && b_out_q[0] && !b_out_q[1] && enable_s;
            lock_event          <= (a_hi_dem & a_lo_dem) | (b_hi_dem & b_lo_dem);
        end
    end

    // pulsed fault flag
    reg [31:0] pulse_cnt_q;
    wire [31:0] hi_fault = PULSE_CYCLES / 32'd100 * `HBG_PULSE_HI_FAULT_PCT;
    wire [31:0] hi_ok    = PULSE_CYCLES / 32'd100 * `HBG_PULSE_HI_OK_PCT;
    always @(posedge i_clock) begin
        if (i_sys_rst)
            pulse_cnt_q <= 32'h0000_0000;
        else if (pulse_cnt_q >= PULSE_CYCLES - 32'h0000_0001)
            pulse_cnt_q <= 32'h0000_0000;
        else
            pulse_cnt_q <= pulse_cnt_q + 32'h0000_0001;
    end
    wire fault_any = fault_s | fault_latch_q;
    wire pulse_lvl = pulse_cnt_q < (fault_any ? hi_fault : hi_ok);

    // diagnostic pin function select
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_diagnostic_pin           <= 1'b0;
            o_open_load_current_select <= 1'b0;
            o_sleep                    <= 1'b0;
        end else begin
            o_open_load_current_select <= config_q[`HBG_CF_OLI];
            o_sleep                    <= !rst_n_s;
            case (dg_sel)
                `HBG_DG_FAULT:  o_diagnostic_pin <= !fault_any; // fault flag, active low
                `HBG_DG_PULSE:  o_diagnostic_pin <= pulse_lvl;
                `HBG_DG_TEMP:   o_diagnostic_pin <= temp_s;
                `HBG_DG_OFFSET: o_diagnostic_pin <= offset_s;
                default:        o_diagnostic_pin <= 1'b0;
            endcase
        end
    end

endmodule

`default_nettype wire

// file: hbg_consts.vh
/*
 constants for the full-bridge gate control block: register offsets,
 field positions, reset values and timing figures.
 assumes inclusion by bare name from the design file.
*/
`ifndef HBG_CONSTS_VH
`define HBG_CONSTS_VH

`define HBG_CLK_MHZ        250
// register byte offsets on the axi4-lite bus
`define HBG_OFF_BRIDGE     8'h00
`define HBG_OFF_CONFIG     8'h04
`define HBG_OFF_DEAD       8'h08
`define HBG_OFF_STATUS     8'h0C
`define HBG_OFF_IRQ_STAT   8'h10
`define HBG_OFF_IRQ_MASK   8'h14
// bridge register fields
`define HBG_BR_AH          0
`define HBG_BR_AL          1
`define HBG_BR_BH          2
`define HBG_BR_BL          3
// config register fields
`define HBG_CF_DG_LO       0
`define HBG_CF_OLI         2
`define HBG_CF_FAULT_LO    4
`define HBG_CFG_RESET      8'h00
// diagnostic select codes
`define HBG_DG_FAULT       2'b00
`define HBG_DG_PULSE       2'b01
`define HBG_DG_TEMP        2'b10
`define HBG_DG_OFFSET      2'b11
// dead time in clock cycles
`define HBG_DEAD_RESET     16'h0064
// timing
`define HBG_PULSE_PERIOD_MS 100
`define HBG_PULSE_CYCLES   (`HBG_PULSE_PERIOD_MS * 1000 * `HBG_CLK_MHZ)
`define HBG_PULSE_HI_FAULT_PCT 80
`define HBG_PULSE_HI_OK_PCT    20
`define HBG_ENABLE_TO_MS   100
`define HBG_ENABLE_TO_CYCLES (`HBG_ENABLE_TO_MS * 1000 * `HBG_CLK_MHZ)
// interrupt status bits
`define HBG_IRQ_FAULT      0
`define HBG_IRQ_DISABLE    1
`define HBG_IRQ_LOCKOUT    2

`endif

// file: hbg_host.sv
/*
 host pin model: drives the four bridge pins one by one, or in tie mode
 one pwm signal per phase onto both pins of that phase.
 assumes the bench changes its inputs just after clock edges.
*/
`default_nettype none
module hbg_host (
    input  wire logic i_tie,
    input  wire logic i_pwm_a,
    input  wire logic i_pwm_b,
    input  wire logic i_ha,
    input  wire logic i_lan_n,
    input  wire logic i_hbn_n,
    input  wire logic i_lb,
    output logic      o_ha,
    output logic      o_lan_n,
    output logic      o_hbn_n,
    output logic      o_lb
);
    timeunit 1ns;
    timeprecision 1ps;
    // pin sense lets one wire per phase pick high or low side
    assign o_ha    = i_tie ? i_pwm_a : i_ha;
    assign o_lan_n = i_tie ? i_pwm_a : i_lan_n;
    assign o_hbn_n = i_tie ? i_pwm_b : i_hbn_n;
    assign o_lb    = i_tie ? i_pwm_b : i_lb;
endmodule
`default_nettype wire

// file: hbg_chk_properties.sv
/*
 checker for hbg_gate_ctrl: gate lockout, hand-over gap, shutdown inputs
 and axi4-lite response timing. assumes binding to the top module.
*/
`default_nettype none
module hbg_chk (
    input wire logic        i_clock,
    input wire logic        i_sys_rst,
    input wire logic        i_enable,
    input wire logic        i_reset_sleep_n,
    input wire logic        o_phase_a_high_gate,
    input wire logic        o_phase_a_low_gate,
    input wire logic        o_phase_b_high_gate,
    input wire logic        o_phase_b_low_gate,
    input wire logic        o_sleep,
    input wire logic        o_diagnostic_pin,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_sys_rst);
    wire any_gate = o_phase_a_high_gate | o_phase_a_low_gate | o_phase_b_high_gate | o_phase_b_low_gate;
    lock_a_a: assert property (!(o_phase_a_high_gate && o_phase_a_low_gate)) else $error("a gates both on");
    lock_b_a: assert property (!(o_phase_b_high_gate && o_phase_b_low_gate)) else $error("b gates both on");
    gap_a_a: assert property ($rose(o_phase_a_high_gate) |-> !$past(o_phase_a_low_gate)) else $error("a no gap");
    gap_b_a: assert property ($rose(o_phase_b_low_gate) |-> !$past(o_phase_b_high_gate)) else $error("b no gap");
    en_off_a: assert property (!i_enable [*4] |-> !any_gate) else $error("gate on while disabled");
    sleep_off_a: assert property (!i_reset_sleep_n [*4] |-> o_sleep && !any_gate) else $error("no sleep");
    b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid repeated");
    r_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid repeated");
    b_after_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("late write response");
    cover property ($rose(o_phase_a_high_gate));
    cover property ($rose(o_phase_b_low_gate));
    cover property ($rose(o_diagnostic_pin));
endmodule
bind hbg_gate_ctrl hbg_chk u_chk (.i_clock, .i_sys_rst, .i_enable, .i_reset_sleep_n, .o_phase_a_high_gate,
    .o_phase_a_low_gate, .o_phase_b_high_gate, .o_phase_b_low_gate, .o_sleep, .o_diagnostic_pin,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// file: tb_hbridge_gate_control_logic.sv
/*
 bench for hbg_gate_ctrl: a table of pin and register cases, then enable,
 dead time, diagnostic, interrupt, sleep and reset cases.
 assumes the host pin model and the bound checker are compiled before.
*/
`default_nettype none
module tb_hbridge_gate_control_logic;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DT = 4;
    logic        clk = 0, rst = 1, tie = 0, pa = 0, pb = 0, ha = 0, lan_n = 1, hbn_n = 1, lb = 0;
    logic        rsn_n = 1, en = 1, flt = 0, tmp = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic [31:0] awa = 0, wd = 0, ara = 0, rd;
    logic [1:0]  rp;
    wire         awr, wr, bv, arr, rv, p_ah, p_al, p_bh, p_bl, g_ah, g_al, g_bh, g_bl, dg, ol, slp, irq;
    wire  [1:0]  bres, rres;
    wire  [31:0] rdat;
    wire  [3:0]  g = {g_ah, g_al, g_bh, g_bl};
    int          n_mismatch = 0, compares = 0, i, n;
    // tie, ha, lan_n, hbn_n, lb, bridge bits {bl, bh, al, ah}, gates {ah, al, bh, bl}
    logic [12:0] rows [12] = '{13'h0C0A, 13'h0305, 13'h0600, 13'h0900, 13'h0699, 13'h0666,
                               13'h06F0, 13'h0E20, 13'h0E18, 13'h0090, 13'h180A, 13'h1205};
    always #2 clk = ~clk;
    hbg_host u_host (.i_tie(tie), .i_pwm_a(pa), .i_pwm_b(pb), .i_ha(ha), .i_lan_n(lan_n), .i_hbn_n(hbn_n),
        .i_lb(lb), .o_ha(p_ah), .o_lan_n(p_al), .o_hbn_n(p_bh), .o_lb(p_bl));
    hbg_gate_ctrl #(.PULSE_CYCLES(32'h0000_0064), .ENABLE_TO_CYC(32'h0000_0032)) dut (.i_clock(clk),
        .i_sys_rst(rst), .i_phase_a_high_pin(p_ah), .i_phase_a_low_pin_n(p_al), .i_phase_b_high_pin_n(p_bh),
        .i_phase_b_low_pin(p_bl), .i_reset_sleep_n(rsn_n), .i_enable(en), .i_fault(flt), .i_temp_indication(tmp),
        .i_offset_indication(1'b0), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bres),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rres), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .o_phase_a_high_gate(g_ah), .o_phase_a_low_gate(g_al), .o_phase_b_high_gate(g_bh),
        .o_phase_b_low_gate(g_bl), .o_diagnostic_pin(dg), .o_open_load_current_select(ol), .o_sleep(slp),
        .o_irq(irq));
    task test_done;
        if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task tmo;
        chk("timeout", 0, 1);
        test_done();
    endtask
    task axw(input logic [7:0] a, input logic [31:0] v);
        logic ta, tw;
        int   k;
        ta = 0;
        tw = 0;
        awa <= {24'h00_0000, a};
        wd <= v;
        awv <= 1;
        wv <= 1;
        br <= 1;
        for (k = 0; k < 40; k++) begin
            @(posedge clk);
            ta = ta || awr === 1'b1;
            tw = tw || wr === 1'b1;
            awv <= !ta;
            wv <= !tw;
            if (bv === 1'b1) break;
        end
        br <= 0;
        if (k == 40) tmo();
        @(posedge clk);
    endtask
    task axr(input logic [7:0] a);
        logic ta;
        int   k;
        ta = 0;
        ara <= {24'h00_0000, a};
        arv <= 1;
        rr <= 1;
        for (k = 0; k < 40; k++) begin
            @(posedge clk);
            ta = ta || arr === 1'b1;
            arv <= !ta;
            rd = rdat;
            rp = rres;
            if (rv === 1'b1) break;
        end
        rr <= 0;
        if (k == 40) tmo();
        @(posedge clk);
    endtask
    // settle floor covers sync, dead time and output register
    task wg(input logic [3:0] e);
        int k;
        for (k = 0; k < 80; k++) begin
            @(posedge clk);
            if (k > DT + 6 && g === e) break;
        end
        if (k == 80) tmo();
    endtask
    task hc;
        int k;
        n = 0;
        for (k = 0; k < 100; k++) begin
            @(posedge clk);
            n += int'(dg === 1'b1);
        end
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        axw(8'h08, 32'(DT));
        for (i = 0; i < 12; i++) begin
            {tie, ha, lan_n, hbn_n, lb} <= rows[i][12:8];
            pa <= rows[i][11];
            pb <= rows[i][9];
            axw(8'h00, {28'h000_0000, rows[i][7:4]});
            wg(rows[i][3:0]);
            chk("gates", g, rows[i][3:0]);
        end
        en <= 0;
        repeat (6) @(posedge clk);
        chk("gates_disabled", g, 0);
        en <= 1;
        axw(8'h08, 32'h0000_0014);
        wg(4'b0101);
        pa <= 1;
        for (n = 0; n < 60 && g[3] !== 1'b1; n++) @(posedge clk);
        chk("dead_time", n >= 20 && n <= 30, 1);
        {tie, ha, lan_n, hbn_n, lb} <= 5'b0_0110;
        axw(8'h00, 32'h0000_0000);
        flt <= 1;
        repeat (6) @(posedge clk);
        chk("diagnostic_pin_fault", dg, 0);
        chk("irq_masked", irq, 0);
        axr(8'h10);
        chk("irq_status", rd[0], 1);
        axw(8'h14, 32'h0000_0001);
        chk("irq_raised", irq, 1);
        axw(8'h10, 32'h0000_0001);
        chk("irq_cleared", irq, 0);
        axr(8'h0C);
        chk("fault_latched", rd[7], 1);
        axw(8'h04, 32'h0000_0001);
        repeat (4) @(posedge clk);
        hc();
        chk("pulse_fault", n, 80);
        flt <= 0;
        repeat (6) @(posedge clk);
        // latched fault keeps the long pulse until a reset_sleep_n pulse
        rsn_n <= 0;
        repeat (6) @(posedge clk);
        chk("sleep", slp, 1);
        rsn_n <= 1;
        repeat (6) @(posedge clk);
        axr(8'h0C);
        chk("fault_unlatched", rd[7], 0);
        hc();
        chk("pulse_clear", n, 20);
        axw(8'h04, 32'h0000_0002);
        tmp <= 1;
        repeat (6) @(posedge clk);
        chk("diagnostic_pin_temp", dg, 1);
        axw(8'h04, 32'h0000_0003);
        repeat (6) @(posedge clk);
        chk("diagnostic_pin_offset", dg, 0);
        axw(8'h04, 32'h0000_0004);
        repeat (2) @(posedge clk);
        chk("olsel", ol, 1);
        axr(8'h20);
        chk("unmapped_resp", rp, 2'b10);
        chk("unmapped_data", rd, 0);
        rst <= 1;
        repeat (3) @(posedge clk);
        chk("reset_outputs", {g, dg, ol}, 0);
        rst <= 0;
        @(posedge clk);
        axr(8'h04);
        chk("config_reset", rd, 0);
        axr(8'h08);
        chk("dead_reset", rd, 32'h0000_0064);
        test_done();
    end
endmodule
`default_nettype wire
